// *** tx_datalink_pkg.sv ***
/*
  Constants, register indices, field layouts and types for the transmit
  datalink message sender. Assumes a single 20 MHz clock domain shared
  with the DS3 transmit framer and an AXI4-Lite register master.
*/
// How it works
// - A 0-to-1 write of the initiate bit starts one message.
// - A zero follows every five consecutive ones in stuffed bytes.
// - A 16-bit frame check sequence follows the message, before the closing flag.
// - Each framer bit request not used for a stuffed zero takes the next message bit, LSB first.
// - Busy reads 1 from the opening flag onward.
// - Busy returns to 0 once the closing flag is sent.
// - With auto-retransmit on, the message repeats once per second.
// - With auto-retransmit off, each start sends exactly one message.
// - Variable-length messages up to one byte fewer than the buffer depth are supported.
// - With transmit enabled, idle flags 0x7e fill every gap between messages.
// - The any-length bit makes the byte count set the message length.
// - Each completed message raises the completion interrupt when enabled.
// - The buffer is reached through an index register and a data register.
package tx_datalink_pkg;
  // Register indices; byte address is four times the index
  localparam logic [13:0] FRAMER_MODE_IDX = 14'h1100;
  localparam logic [13:0] MSG_CONFIG_IDX = 14'h1133;
  localparam logic [13:0] MSG_STATUS_IDX = 14'h1134;
  localparam logic [13:0] BYTE_COUNT_IDX = 14'h1183;
  localparam logic [13:0] BUF_INDEX_IDX = 14'h11c0;
  localparam logic [13:0] BUF_DATA_IDX = 14'h11c1;

  localparam int ST_INIT_BIT = 3;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_IEN_BIT = 1;
  localparam int ST_ISTAT_BIT = 0;
  localparam logic IEN_RESET = 1'b1;

  typedef struct packed {
    logic anyLength;
    logic [2:0] unused6to4;
    logic autoRetransmit;
    logic unused2;
    logic longMessage;
    logic txEnable;
  } cfg_t;
  localparam cfg_t CFG_RESET = '{default: 1'b0};
  localparam logic [7:0] CFG_WRITE_MASK = 8'h8b;

  localparam logic [7:0] FLAG_BYTE = 8'h7e;
  localparam logic [7:0] STD_LAST_SHORT = 8'h4f;
  localparam logic [7:0] STD_LAST_LONG = 8'h55;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] ONES_LIMIT = 3'h5;
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam longint ONE_SEC_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 50;
  localparam int SEC_CYCLES_DEF = int'(ONE_SEC_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPEN = 3'b001,
    S_BODY = 3'b010,
    S_FCS1 = 3'b011,
    S_FCS2 = 3'b100,
    S_CLOSE = 3'b101,
    S_WAIT = 3'b110
  } tx_state_t;
endpackage

// *** tx_datalink_message_sender.sv ***
/*
  Transmit datalink message sender: AXI4-Lite register slave, message
  buffer, zero stuffing, FCS generation and serialiser into the DS3
  datalink overhead bits. Assumes dlBitReq comes from framer logic on clk.
*/
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module tx_datalink_message_sender #(
  parameter int BUF_DEPTH = 88,
  parameter int SEC_CYCLES = tx_datalink_pkg::SEC_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dlBitReq,
  output logic datalinkOverheadBits,
  output logic irq
);
  localparam int BUF_IW = $clog2(BUF_DEPTH);

  initial begin
    // Standard long frames index up to STD_LAST_LONG; the index register is only 8 bits
    if (BUF_DEPTH <= int'(tx_datalink_pkg::STD_LAST_LONG) || BUF_DEPTH > 255) $error("BUF_DEPTH out of range");
    if (SEC_CYCLES < 2 || SEC_CYCLES >= (1 << 25)) $error("SEC_CYCLES out of range");
  end

  // Reset release through two flops
  logic rstSync1R, rstN;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1R <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1R <= 1'b1;
      rstN <= rstSync1R;
    end
  end

  // AXI4-Lite write channels
  logic awHeldR, wHeldR, wrEn, wrHit;
  logic [13:0] awIdxR;
  logic [31:0] wDataR;
  logic [3:0] wStrbR;
  assign wrEn = awHeldR && wHeldR && !s_axi_bvalid;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awHeldR <= 1'b0;
      wHeldR <= 1'b0;
      awIdxR <= '0;
      wDataR <= '0;
      wStrbR <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tx_datalink_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldR <= 1'b1;
        awIdxR <= s_axi_awaddr[15:2];
        s_axi_awready <= 1'b0;
      end else if (!awHeldR) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldR <= 1'b1;
        wDataR <= s_axi_wdata;
        wStrbR <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wHeldR) begin
        s_axi_wready <= 1'b1;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? tx_datalink_pkg::RESP_OKAY : tx_datalink_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeldR <= 1'b0;
        wHeldR <= 1'b0;
      end
    end
  end

  logic wrLane0, wrMode, wrCfg, wrStat, wrCount, wrBufIdx, wrBufData;
  assign wrLane0 = wrEn && wStrbR[0];
  assign wrMode = wrLane0 && awIdxR == tx_datalink_pkg::FRAMER_MODE_IDX;
  assign wrCfg = wrLane0 && awIdxR == tx_datalink_pkg::MSG_CONFIG_IDX;
  assign wrStat = wrLane0 && awIdxR == tx_datalink_pkg::MSG_STATUS_IDX;
  assign wrCount = wrLane0 && awIdxR == tx_datalink_pkg::BYTE_COUNT_IDX;
  assign wrBufIdx = wrLane0 && awIdxR == tx_datalink_pkg::BUF_INDEX_IDX;
  assign wrBufData = wrLane0 && awIdxR == tx_datalink_pkg::BUF_DATA_IDX;
  assign wrHit = awIdxR inside {tx_datalink_pkg::FRAMER_MODE_IDX, tx_datalink_pkg::MSG_CONFIG_IDX,
                                tx_datalink_pkg::MSG_STATUS_IDX, tx_datalink_pkg::BYTE_COUNT_IDX,
                                tx_datalink_pkg::BUF_INDEX_IDX, tx_datalink_pkg::BUF_DATA_IDX};

  // Software registers
  logic [7:0] modeR, byteCountR, bufIdxR;
  tx_datalink_pkg::cfg_t cfgR;
  logic initBitR, intEnR, intStatR, busyR, startPendR, doneEvt, rdStat, enterOpen;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      modeR <= '0;
      cfgR <= tx_datalink_pkg::CFG_RESET;
      byteCountR <= '0;
      bufIdxR <= '0;
      initBitR <= 1'b0;
      intEnR <= tx_datalink_pkg::IEN_RESET;
    end else begin
      if (wrMode) modeR <= wDataR[7:0];
      if (wrCfg) cfgR <= tx_datalink_pkg::cfg_t'(wDataR[7:0] & tx_datalink_pkg::CFG_WRITE_MASK);
      if (wrCount) byteCountR <= wDataR[7:0];
      if (wrBufIdx) bufIdxR <= wDataR[7:0];
      if (wrStat) begin
        initBitR <= wDataR[tx_datalink_pkg::ST_INIT_BIT];
        intEnR <= wDataR[tx_datalink_pkg::ST_IEN_BIT];
      end
    end
  end

  // Start request; cleared when the opening flag begins
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) startPendR <= 1'b0;
    else if (wrStat && wDataR[tx_datalink_pkg::ST_INIT_BIT] && !initBitR) startPendR <= 1'b1;
    else if (enterOpen || !cfgR.txEnable) startPendR <= 1'b0;
  end

  // Completion status: set beats clear-on-read and write-one-to-clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) intStatR <= 1'b0;
    else if (doneEvt) intStatR <= 1'b1;
    else if (rdStat || (wrStat && wDataR[tx_datalink_pkg::ST_ISTAT_BIT])) intStatR <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) irq <= 1'b0;
    else irq <= intStatR && intEnR;
  end

  // Message buffer
  logic [7:0] bufMem [BUF_DEPTH];
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : gBuf
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) bufMem[i] <= '0;
      else if (wrBufData && bufIdxR == 8'(i)) bufMem[i] <= wDataR[7:0];
    end
  end

  // AXI4-Lite read channel
  logic [7:0] rdByte;
  logic rdHit;
  logic [13:0] arIdx;
  assign arIdx = s_axi_araddr[15:2];
  assign rdStat = s_axi_arvalid && s_axi_arready && arIdx == tx_datalink_pkg::MSG_STATUS_IDX;
  always_comb begin
    rdByte = '0;
    rdHit = 1'b1;
    case (arIdx)
      tx_datalink_pkg::FRAMER_MODE_IDX: rdByte = modeR;
      tx_datalink_pkg::MSG_CONFIG_IDX: rdByte = cfgR;
      tx_datalink_pkg::MSG_STATUS_IDX: rdByte = {4'h0, initBitR, busyR, intEnR, intStatR};
      tx_datalink_pkg::BYTE_COUNT_IDX: rdByte = byteCountR;
      tx_datalink_pkg::BUF_INDEX_IDX: rdByte = bufIdxR;
      tx_datalink_pkg::BUF_DATA_IDX: rdByte = (bufIdxR < 8'(BUF_DEPTH)) ? bufMem[bufIdxR[BUF_IW-1:0]] : 8'h00;
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tx_datalink_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rdByte};
      s_axi_rresp <= rdHit ? tx_datalink_pkg::RESP_OKAY : tx_datalink_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Serialiser
  tx_datalink_pkg::tx_state_t stateR, stateNxt;
  logic [7:0] shiftR, byteNxt, idxR, idxNxt, lastIdx;
  logic [2:0] bitCntR, onesR;
  logic [15:0] crcR, crcNxt;
  logic [24:0] secCntR;
  logic stuffing, insertZero, bitTake, byteEnd, secDone;

  // Standard frames have a fixed size; any-length uses the byte count
  assign lastIdx = cfgR.anyLength ? ((byteCountR < 8'(BUF_DEPTH)) ? byteCountR : 8'(BUF_DEPTH - 1))
                 : (cfgR.longMessage ? tx_datalink_pkg::STD_LAST_LONG : tx_datalink_pkg::STD_LAST_SHORT);
  // A zero owed after trailing FCS ones still goes out before the closing flag
  assign stuffing = stateR inside {tx_datalink_pkg::S_BODY, tx_datalink_pkg::S_FCS1, tx_datalink_pkg::S_FCS2} ||
                    (stateR == tx_datalink_pkg::S_CLOSE && bitCntR == 3'h0);
  assign insertZero = stuffing && onesR == tx_datalink_pkg::ONES_LIMIT;
  assign bitTake = dlBitReq && cfgR.txEnable && !insertZero;
  assign byteEnd = bitTake && bitCntR == tx_datalink_pkg::LAST_BIT;
  assign crcNxt = {1'b0, crcR[15:1]} ^ ((crcR[0] ^ shiftR[0]) ? tx_datalink_pkg::CRC_POLY : 16'h0000);
  assign secDone = secCntR == 25'(SEC_CYCLES - 1);
  assign enterOpen = byteEnd && stateNxt == tx_datalink_pkg::S_OPEN;
  assign doneEvt = byteEnd && stateR == tx_datalink_pkg::S_CLOSE;

  always_comb begin
    stateNxt = stateR;
    byteNxt = tx_datalink_pkg::FLAG_BYTE;
    idxNxt = idxR;
    case (stateR)
      tx_datalink_pkg::S_IDLE: begin
        if (startPendR) begin
          stateNxt = tx_datalink_pkg::S_OPEN;
          byteNxt = bufMem[0];
          idxNxt = '0;
        end
      end
      tx_datalink_pkg::S_WAIT: begin
        if (startPendR || (cfgR.autoRetransmit && secDone)) begin
          stateNxt = tx_datalink_pkg::S_OPEN;
          byteNxt = bufMem[0];
          idxNxt = '0;
        end else if (!cfgR.autoRetransmit) begin
          stateNxt = tx_datalink_pkg::S_IDLE;
        end
      end
      tx_datalink_pkg::S_OPEN: begin
        stateNxt = tx_datalink_pkg::S_BODY;
        byteNxt = bufMem[1];
        idxNxt = 8'h01;
      end
      tx_datalink_pkg::S_BODY: begin
        if (idxR >= lastIdx) begin
          stateNxt = tx_datalink_pkg::S_FCS1;
          byteNxt = ~crcNxt[7:0];
        end else begin
          idxNxt = idxR + 8'h01;
          byteNxt = bufMem[idxNxt[BUF_IW-1:0]];
        end
      end
      tx_datalink_pkg::S_FCS1: begin
        stateNxt = tx_datalink_pkg::S_FCS2;
        byteNxt = ~crcR[15:8];
      end
      tx_datalink_pkg::S_FCS2: stateNxt = tx_datalink_pkg::S_CLOSE;
      tx_datalink_pkg::S_CLOSE: stateNxt = cfgR.autoRetransmit ? tx_datalink_pkg::S_WAIT : tx_datalink_pkg::S_IDLE;
      default: stateNxt = tx_datalink_pkg::S_IDLE;
    endcase
  end

  // Byte sequencing; disabling drops any frame in flight
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stateR <= tx_datalink_pkg::S_IDLE;
      shiftR <= tx_datalink_pkg::FLAG_BYTE;
      bitCntR <= '0;
      idxR <= '0;
    end else if (!cfgR.txEnable) begin
      stateR <= tx_datalink_pkg::S_IDLE;
      shiftR <= tx_datalink_pkg::FLAG_BYTE;
      bitCntR <= '0;
    end else if (bitTake) begin
      bitCntR <= bitCntR + 3'h1;
      if (byteEnd) begin
        stateR <= stateNxt;
        shiftR <= byteNxt;
        idxR <= idxNxt;
      end else begin
        shiftR <= {1'b0, shiftR[7:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) onesR <= '0;
    else if (!cfgR.txEnable) onesR <= '0;
    // Owed zero waits for a bit slot; slots may be several cycles apart
    else if (dlBitReq) begin
      if (!stuffing || insertZero) onesR <= '0;
      else onesR <= shiftR[0] ? onesR + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) crcR <= tx_datalink_pkg::CRC_INIT;
    else if (enterOpen) crcR <= tx_datalink_pkg::CRC_INIT;
    else if (bitTake && stateR == tx_datalink_pkg::S_BODY) crcR <= crcNxt;
  end

  // Line idles high while disabled
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) datalinkOverheadBits <= 1'b1;
    else if (!cfgR.txEnable) datalinkOverheadBits <= 1'b1;
    else if (dlBitReq) datalinkOverheadBits <= insertZero ? 1'b0 : shiftR[0];
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) busyR <= 1'b0;
    else if (enterOpen) busyR <= 1'b1;
    else if (doneEvt || !cfgR.txEnable) busyR <= 1'b0;
  end

  // Interval measured from each opening flag
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) secCntR <= '0;
    else if (enterOpen) secCntR <= '0;
    else if (!secDone) secCntR <= secCntR + 25'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence closeEndS;
    doneEvt;
  endsequence
  sequence startWriteS;
    wrStat && wDataR[tx_datalink_pkg::ST_INIT_BIT] && !initBitR && cfgR.txEnable;
  endsequence

  start_edge_a: assert property (startWriteS |=> startPendR || busyR) else $error("start lost");
  stuff_zero_a: assert property (dlBitReq && cfgR.txEnable && insertZero |=> !datalinkOverheadBits && onesR == 3'h0)
    else $error("no stuffed zero");
  stuff_hold_a: assert property (insertZero && !dlBitReq && cfgR.txEnable |=> insertZero)
    else $error("stuffed zero dropped between slots");
  fcs_load_a: assert property (byteEnd && stateR == tx_datalink_pkg::S_BODY && idxR >= lastIdx |=>
    stateR == tx_datalink_pkg::S_FCS1 && shiftR == ~$past(crcNxt[7:0])) else $error("fcs not loaded");
  bit_out_a: assert property (dlBitReq && cfgR.txEnable && !insertZero |=> datalinkOverheadBits == $past(shiftR[0]))
    else $error("wrong datalink bit");
  busy_set_a: assert property (enterOpen |=> busyR ##1 (busyR || doneEvt || !cfgR.txEnable)) else $error("busy not set");
  busy_drop_a: assert property (closeEndS |=> !busyR) else $error("busy stuck after frame");
  auto_wait_a: assert property (closeEndS and cfgR.autoRetransmit |=> stateR == tx_datalink_pkg::S_WAIT)
    else $error("no retransmit wait");
  one_shot_a: assert property (closeEndS and !cfgR.autoRetransmit |=> stateR == tx_datalink_pkg::S_IDLE)
    else $error("one-shot did not idle");
  idle_flag_a: assert property (byteEnd && stateR == tx_datalink_pkg::S_IDLE && !startPendR |=>
    shiftR == tx_datalink_pkg::FLAG_BYTE) else $error("idle flag missing");
  length_sel_a: assert property (cfgR.anyLength && byteCountR < 8'(BUF_DEPTH) |-> lastIdx == byteCountR)
    else $error("any-length ignored");
  done_irq_a: assert property (closeEndS ##1 intEnR |=> irq) else $error("completion irq missing");
  read_clear_a: assert property (rdStat && !doneEvt |=> !intStatR ##1 !irq || intStatR) else $error("status not cleared");
endmodule

// *** dl_framer_model.sv ***
/*
  Far-side framer model: offers datalink bit slots at random spacing and
  de-frames the returned bit stream into flags and whole frames.
  Assumes the sender puts each bit on its output the cycle after the slot.
*/
`timescale 1ns/1ps
module dl_framer_model (
  input wire logic clk,
  input wire logic rstN,
  output logic dlBitReq,
  input wire logic dlBit
);
  int seed = 32'hc8c0643f;
  int gap = 0;
  int ones = 0;
  int frameCount = 0;
  int flagCount = 0;
  int bitCount = 0;
  logic pend = 1'b0;
  logic [7:0] rawWin = 8'h00;
  logic bits[$];
  logic [7:0] frame[$];

  // Gaps of zero give back-to-back slots, the tightest legal spacing
  initial begin
    dlBitReq = 1'b0;
    forever begin
      @(posedge clk);
      dlBitReq <= rstN && gap == 0;
      gap = (gap > 0) ? gap - 1 : $unsigned($random(seed)) % 3;
    end
  end

  task automatic take(input logic b);
    logic [7:0] v;
    bitCount++;
    rawWin = {b, rawWin[7:1]};
    if (ones == 5 && !b) begin
      ones = 0;
    end else begin
      bits.push_back(b);
      ones = b ? ones + 1 : 0;
    end
    if (rawWin == 8'h7e) begin
      flagCount++;
      // Only whole-byte content between two flags counts as a frame
      if (bits.size() > 8 && bits.size() % 8 == 0) begin
        frame.delete();
        for (int i = 0; i < bits.size() - 8; i++) begin
          v[i % 8] = bits[i];
          if (i % 8 == 7) frame.push_back(v);
        end
        frameCount++;
      end
      bits.delete();
      ones = 0;
    end
  endtask

  always @(posedge clk) begin
    pend <= dlBitReq;
    if (pend) take(dlBit);
  end
endmodule

// *** tx_datalink_message_sender_bench.sv ***
/*
  Self-checking bench for the transmit datalink message sender: AXI4-Lite
  master tasks, random message content, framer model on the datalink side.
  Assumes a shortened one-second count so auto-retransmit fits the run.
*/
`timescale 1ns/1ps
module tx_datalink_message_sender_bench;
  localparam int SEC = 3000;
  localparam logic [13:0] ST = tx_datalink_pkg::MSG_STATUS_IDX;
  localparam logic [13:0] CF = tx_datalink_pkg::MSG_CONFIG_IDX;
  localparam logic [13:0] BC = tx_datalink_pkg::BYTE_COUNT_IDX;
  localparam logic [13:0] BI = tx_datalink_pkg::BUF_INDEX_IDX;
  localparam logic [13:0] BD = tx_datalink_pkg::BUF_DATA_IDX;
  localparam logic [1:0] ERR = tx_datalink_pkg::RESP_SLVERR;
  logic clk, nrst, dlBitReq, dlBit, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdVal;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] msg[0:87];
  logic [15:0] crc;
  int seed = 32'hc8c0643f;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n, f0, t1;

  tx_datalink_message_sender #(.BUF_DEPTH(88), .SEC_CYCLES(SEC)) dut (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dlBitReq(dlBitReq), .datalinkOverheadBits(dlBit), .irq(irq)
  );

  dl_framer_model model (.clk(clk), .rstN(nrst), .dlBitReq(dlBitReq), .dlBit(dlBit));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdVal = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? (c >> 1) ^ tx_datalink_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  task automatic chk_frame(input int len);
    crc = 16'hffff;
    check(model.frame.size(), len + 2);
    for (int i = 1; i <= len; i++) begin
      crc = crc_step(crc, msg[i]);
      check(model.frame[i - 1], msg[i]);
    end
    crc = ~crc;
    check(model.frame[len], crc[7:0]);
    check(model.frame[len + 1], crc[15:8]);
  endtask

  // Twelve flags in a row must span exactly twelve bytes of bits
  task automatic idle_check();
    int fc, bc;
    fc = model.flagCount;
    while (model.flagCount == fc) @(posedge clk);
    fc = model.flagCount;
    bc = model.bitCount;
    while (model.flagCount < fc + 12) @(posedge clk);
    check(model.bitCount - bc, 96);
  endtask

  initial begin
    nrst = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check(dlBit, 1'b1);
    rd(ST);
    check(rdVal, 32'h2);
    rd(CF);
    check(rdVal, 32'h0);
    rd(14'h0001);
    check(resp, ERR);
    wr(14'h0001, 8'hff);
    check(resp, ERR);
    wr(tx_datalink_pkg::FRAMER_MODE_IDX, 8'h40);
    wr(CF, 8'hff);
    check(resp, tx_datalink_pkg::RESP_OKAY);
    rd(CF);
    check(rdVal, 32'h8b);
    wr(CF, 8'h81);
    idle_check();
    // All-ones payload forces stuffing; last pass is standard length
    for (int c = 0; c < 3; c++) begin
      n = (c == 2) ? 79 : (c == 0) ? 5 : 1 + $unsigned($random(seed)) % 20;
      wr(CF, (c == 2) ? 8'h01 : 8'h81);
      wr(BC, (c == 2) ? 8'h03 : n[7:0]);
      msg[0] = 8'h7e;
      for (int i = 0; i <= n; i++) begin
        if (i > 0) msg[i] = (c == 0) ? 8'hff : 8'($random(seed));
        wr(BI, i[7:0]);
        wr(BD, msg[i]);
      end
      // Index still points at the last byte written
      rd(BD);
      check(rdVal, {24'h0, msg[n]});
      f0 = model.frameCount;
      wr(ST, (c == 1) ? 8'h08 : 8'h0a);
      rd(ST);
      for (int k = 0; k < 30 && rdVal[2] !== 1'b1; k++) rd(ST);
      check(rdVal[2], 1'b1);
      while (model.frameCount == f0) @(posedge clk);
      repeat (3) @(posedge clk);
      check(irq, c != 1);
      chk_frame(n);
      rd(ST);
      check(rdVal, (c == 1) ? 32'h9 : 32'hb);
      rd(ST);
      check(rdVal[0], 1'b0);
      check(irq, 1'b0);
      // Initiate still 1: a repeated write is no new start
      wr(ST, (c == 1) ? 8'h08 : 8'h0a);
      repeat (400) @(posedge clk);
      check(model.frameCount, f0 + 1);
      wr(ST, (c == 1) ? 8'h00 : 8'h02);
    end
    idle_check();
    wr(BC, 8'h03);
    wr(CF, 8'h89);
    f0 = model.frameCount;
    wr(ST, 8'h0a);
    while (model.frameCount == f0) @(posedge clk);
    t1 = cyc;
    while (model.frameCount == f0 + 1) @(posedge clk);
    check((cyc - t1 > SEC - 100) && (cyc - t1 < SEC + 100), 1'b1);
    chk_frame(3);
    wr(CF, 8'h81);
    wr(ST, 8'h02);
    f0 = model.frameCount;
    repeat (SEC + 500) @(posedge clk);
    check(model.frameCount, f0);
    wr(CF, 8'h00);
    repeat (30) @(posedge clk);
    check(dlBit, 1'b1);
    finish_test();
  end

  // Whole sequence needs about 11000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
